// ===== psc_defines.svh
// Bit layout, reset value and framing constants of the control word
`ifndef PSC_DEFINES_SVH
`define PSC_DEFINES_SVH

`define PSC_WORD_W 32
`define PSC_CNT_W 6
`define PSC_SEL_LSB 0
`define PSC_SEL_W 2
`define PSC_SEL_CODE 2'h2
`define PSC_POL_BIT 2
`define PSC_PRESET_BIT 3
`define PSC_CUR_LSB 4
`define PSC_CUR_W 4
`define PSC_PFD_LSB 8
`define PSC_PFD_W 2
`define PSC_FB_LSB 10
`define PSC_FB_W 3
`define PSC_PAIR_LSB 13
`define PSC_PAIR_W 3
`define PSC_PAIRS 5
`define PSC_SLEEP_N_BIT 28
`define PSC_FUNC_BIT 29
`define PSC_DIV_RUN_BIT 30
`define PSC_PUMP_RUN_BIT 31
`define PSC_RESET_VAL 32'hDB6DB4A2
`define PSC_SYNC_STAGES 3

`endif

// ===== psc_host_model.sv
// Host side of the three-wire serial configuration link
`timescale 1ns/1ps
`default_nettype none

module psc_host_model (
   // Clock
   input wire logic ref_clk,
   // Serial pins toward the device
   output logic ser_clk,
   output logic ser_data,
   output logic ser_latch
);
   initial begin
      ser_clk = 1'b0;
      ser_data = 1'b0;
      ser_latch = 1'b1;
   end

   // Every level is held four cycles so the device filter always sees it
   task automatic send(input logic [31:0] w, input int n);
      @(negedge ref_clk);
      ser_latch = 1'b0;
      repeat (4) @(negedge ref_clk);
      for (int i = n - 1; i >= 0; i--) begin
         // Bits beyond the word width go out as zeros, first
         ser_data = (i < 32) ? w[i] : 1'b0;
         repeat (4) @(negedge ref_clk);
         ser_clk = 1'b1;
         repeat (4) @(negedge ref_clk);
         ser_clk = 1'b0;
         repeat (4) @(negedge ref_clk);
      end
      ser_latch = 1'b1;
      // Data means nothing outside a frame; flip it so nobody relies on it
      ser_data = ~ser_data;
   endtask

   // Clock pulses with the latch high must leave the device untouched
   task automatic stray(input int n);
      for (int i = 0; i < n; i++) begin
         ser_data = ~ser_data;
         repeat (4) @(negedge ref_clk);
         ser_clk = 1'b1;
         repeat (4) @(negedge ref_clk);
         ser_clk = 1'b0;
         repeat (4) @(negedge ref_clk);
      end
   endtask
endmodule

`default_nettype wire

// ===== psc_pin_sync.sv
// Three-stage synchroniser with agreement filter for asynchronous pins
`timescale 1ns/1ps
`default_nettype none

module psc_pin_sync #(
   parameter int WIDTH = 4,
   parameter logic [WIDTH-1:0] RESET_LEVEL = '0
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic sys_rst,
   // Pins and filtered levels
   input wire logic [WIDTH-1:0] pin_async,
   output logic [WIDTH-1:0] pin_level
);

   logic [WIDTH-1:0] stage1;
   logic [WIDTH-1:0] stage2;
   logic [WIDTH-1:0] stage3;

   // Stage one feeds only stage two, to keep metastability contained
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         stage1 <= RESET_LEVEL;
         stage2 <= RESET_LEVEL;
         stage3 <= RESET_LEVEL;
      end else begin
         stage1 <= pin_async;
         stage2 <= stage1;
         stage3 <= stage2;
      end
   end

   // A change is taken only once the later two stages agree
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         pin_level <= RESET_LEVEL;
      end else begin
         for (int i = 0; i < WIDTH; i++) begin
            if (stage2[i] == stage3[i]) begin
               pin_level[i] <= stage3[i];
            end
         end
      end
   end

endmodule

`default_nettype wire

// ===== psc_pkg.sv
// Types shared by the control word logic
`include "psc_defines.svh"

package psc_pkg;

   typedef struct packed {
      logic pump_polarity;
      logic pump_preset_half_supply;
      logic [`PSC_CUR_W-1:0] pump_current;
      logic [`PSC_PFD_W-1:0] detector_pulse_width;
      logic [`PSC_FB_W-1:0] feedback_source;
      logic [`PSC_PAIRS*`PSC_PAIR_W-1:0] pair_source;
      logic outputs_sleep_n;
      logic shared_pin_function;
      logic dividers_run;
      logic pump_run;
   } psc_fields_type;

   typedef struct packed {
      logic ser_clk;
      logic ser_data;
      logic ser_latch;
      logic shared_ctl_n;
   } psc_pins_type;

   typedef enum logic [0:0] {
      psc_rx_idle,
      psc_rx_shift
   } psc_rx_state_type;

endpackage

// ===== psc_word_two.sv
// Serially loaded charge-pump, multiplexer and power control word
//
// Summary of operation
// - Bit 2 sets pump current polarity.
// - Bit 3 presets pump to half supply.
// - Bits 4-7 select pump current, MSB first.
// - Bits 8-9 select detector pulse width.
// - Bits 10-12 select feedback multiplexer source.
// - Five three-bit pair sources from bit 13.
// - Bit 28 low powers outputs down.
// - Bit 29 picks shared pin: reset/hold.
// - Bit 30 low resets all dividers.
// - Bit 31 low tristates the charge pump.
`timescale 1ns/1ps
`default_nettype none

module psc_word_two
   import psc_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic sys_rst,
   // Serial configuration pins
   input wire logic ser_clk,
   input wire logic ser_data,
   input wire logic ser_latch,
   // Shared reset or hold pin, active low
   input wire logic shared_ctl_n,
   // Decoded word and whole word image
   output var psc_fields_type cfg,
   output logic [`PSC_WORD_W-1:0] word_image,
   // Effective controls toward the PLL core
   output logic dividers_reset,
   output logic pump_tristate,
   // Frame outcome pulses
   output logic load_done,
   output logic frame_reject
);

   localparam logic [`PSC_CNT_W-1:0] FULL_COUNT =
      `PSC_CNT_W'(`PSC_WORD_W);
   localparam logic [`PSC_CNT_W-1:0] MAX_COUNT = '1;
   localparam psc_pins_type PIN_IDLE = '{
      ser_clk: 1'b0,
      ser_data: 1'b0,
      ser_latch: 1'b1,
      shared_ctl_n: 1'b1
   };

   psc_pins_type pins_raw;
   psc_pins_type pins;
   psc_pins_type pins_prev;
   psc_rx_state_type rx_state;
   psc_rx_state_type next_rx_state;
   logic [`PSC_WORD_W-1:0] shift_reg;
   logic [`PSC_CNT_W-1:0] bit_count;
   logic [`PSC_WORD_W-1:0] word;
   logic clk_rise;
   logic latch_rise;
   logic latch_fall;
   logic frame_ok;
   logic pin_asserted;

   // Splits a stored word into its fields
   function automatic psc_fields_type decode(
      input logic [`PSC_WORD_W-1:0] w
   );
      psc_fields_type f;
      f.pump_polarity = w[`PSC_POL_BIT];
      f.pump_preset_half_supply = w[`PSC_PRESET_BIT];
      f.pump_current = w[`PSC_CUR_LSB +: `PSC_CUR_W];
      f.detector_pulse_width = w[`PSC_PFD_LSB +: `PSC_PFD_W];
      f.feedback_source = w[`PSC_FB_LSB +: `PSC_FB_W];
      f.pair_source =
         w[`PSC_PAIR_LSB +: `PSC_PAIRS*`PSC_PAIR_W];
      f.outputs_sleep_n = w[`PSC_SLEEP_N_BIT];
      f.shared_pin_function = w[`PSC_FUNC_BIT];
      f.dividers_run = w[`PSC_DIV_RUN_BIT];
      f.pump_run = w[`PSC_PUMP_RUN_BIT];
      return f;
   endfunction

   // Divider reset: register bit low, or pin low while in reset role
   function automatic logic divider_reset_of(
      input logic [`PSC_WORD_W-1:0] w,
      input logic pin_on
   );
      return !w[`PSC_DIV_RUN_BIT] ||
         (!w[`PSC_FUNC_BIT] && pin_on);
   endfunction

   // Pump tristate: register bit low, or pin low while in hold role
   function automatic logic pump_tristate_of(
      input logic [`PSC_WORD_W-1:0] w,
      input logic pin_on
   );
      return !w[`PSC_PUMP_RUN_BIT] ||
         (w[`PSC_FUNC_BIT] && pin_on);
   endfunction

   assign pins_raw.ser_clk = ser_clk;
   assign pins_raw.ser_data = ser_data;
   assign pins_raw.ser_latch = ser_latch;
   assign pins_raw.shared_ctl_n = shared_ctl_n;

   // All four pins come from outside this clock domain
   psc_pin_sync #(
      .WIDTH($bits(psc_pins_type)),
      .RESET_LEVEL(PIN_IDLE)
   ) u_pin_sync (
      .ref_clk(ref_clk),
      .sys_rst(sys_rst),
      .pin_async(pins_raw),
      .pin_level(pins)
   );

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         pins_prev <= PIN_IDLE;
      end else begin
         pins_prev <= pins;
      end
   end

   // Data passes the same synchroniser depth as the clock, so the
   // host's setup time around its clock edge is preserved
   assign clk_rise = pins.ser_clk && !pins_prev.ser_clk;
   assign latch_rise = pins.ser_latch && !pins_prev.ser_latch;
   assign latch_fall = !pins.ser_latch && pins_prev.ser_latch;
   assign pin_asserted = !pins.shared_ctl_n;

   // Frame is shifting while the latch pin is low
   always_comb begin
      next_rx_state = rx_state;
      case (rx_state)
         psc_rx_idle: begin
            if (latch_fall) begin
               next_rx_state = psc_rx_shift;
            end
         end
         psc_rx_shift: begin
            if (latch_rise) begin
               next_rx_state = psc_rx_idle;
            end
         end
         default: begin
            next_rx_state = psc_rx_idle;
         end
      endcase
   end

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         rx_state <= psc_rx_idle;
      end else begin
         rx_state <= next_rx_state;
      end
   end

   // Most significant bit arrives first; the select bits come last
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         shift_reg <= '0;
      end else if (rx_state == psc_rx_shift && clk_rise) begin
         shift_reg <= {shift_reg[`PSC_WORD_W-2:0], pins.ser_data};
      end
   end

   // Saturating count lets an over-long frame be told from a full one
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         bit_count <= '0;
      end else if (rx_state == psc_rx_idle) begin
         bit_count <= '0;
      end else if (clk_rise && bit_count != MAX_COUNT) begin
         bit_count <= bit_count + `PSC_CNT_W'(1);
      end
   end

   // Frames for the other words carry another select code
   assign frame_ok = (bit_count == FULL_COUNT) &&
      (shift_reg[`PSC_SEL_LSB +: `PSC_SEL_W] == `PSC_SEL_CODE);

   // The word only changes on a whole frame addressed to it
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         word <= `PSC_RESET_VAL;
      end else if (rx_state == psc_rx_shift && latch_rise && frame_ok) begin
         word <= shift_reg;
      end
   end

   // Frame outcome pulses, one cycle each
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         load_done <= 1'b0;
         frame_reject <= 1'b0;
      end else begin
         load_done <= rx_state == psc_rx_shift && latch_rise && frame_ok;
         frame_reject <= rx_state == psc_rx_shift && latch_rise &&
            !frame_ok;
      end
   end

   // Registered view of the word toward the PLL core
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         cfg <= decode(`PSC_RESET_VAL);
         word_image <= `PSC_RESET_VAL;
      end else begin
         cfg <= decode(word);
         word_image <= word;
      end
   end

   // Register bit and shared pin act alike; the role bit picks which
   // pump or divider control the pin joins
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         dividers_reset <= 1'b0;
         pump_tristate <= 1'b0;
      end else begin
         dividers_reset <= divider_reset_of(word, pin_asserted);
         pump_tristate <= pump_tristate_of(word, pin_asserted);
      end
   end

endmodule

`default_nettype wire

// ===== psc_word_two_sva.sv
// Port checks for the serially loaded control word
`timescale 1ns/1ps
`default_nettype none

module psc_word_two_sva
   import psc_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic sys_rst,
   // Pin and outputs
   input wire logic shared_ctl_n,
   input wire psc_fields_type cfg,
   input wire logic [31:0] word_image,
   input wire logic dividers_reset,
   input wire logic pump_tristate,
   input wire logic load_done,
   input wire logic frame_reject
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (sys_rst);

   sequence load_seq;
      load_done ##1 (word_image[1:0] == 2'h2);
   endsequence

   pump_fields_a: assert property (
      {cfg.detector_pulse_width, cfg.pump_current,
       cfg.pump_preset_half_supply, cfg.pump_polarity} == word_image[9:2])
      else $error("pump fields wrong");
   mux_fields_a: assert property (
      {cfg.pump_run, cfg.dividers_run, cfg.shared_pin_function,
       cfg.outputs_sleep_n, cfg.pair_source, cfg.feedback_source}
      == word_image[31:10]) else $error("mux fields wrong");
   div_reset_a: assert property (
      shared_ctl_n [*8] |-> dividers_reset == !word_image[30])
      else $error("divider reset wrong");
   pump_hold_a: assert property (
      shared_ctl_n [*8] |-> pump_tristate == !word_image[31])
      else $error("pump tristate wrong");
   // Eight low cycles outlast the pin filter, so the outputs have settled
   pin_route_a: assert property (
      !shared_ctl_n [*8] |->
      dividers_reset == !(word_image[30] && word_image[29]) &&
      pump_tristate == !(word_image[31] && !word_image[29]))
      else $error("shared pin routed wrong");
   load_code_a: assert property (
      load_done |-> load_seq) else $error("load with bad code");
   word_change_a: assert property (
      $changed(word_image) |-> $past(load_done))
      else $error("word changed without load");
   reject_keep_a: assert property (
      frame_reject |=> $stable(word_image) [*2])
      else $error("rejected frame changed word");
   pulse_width_a: assert property (
      (load_done || frame_reject) |=> !load_done && !frame_reject)
      else $error("outcome pulse too long");
   reset_val_a: assert property (
      $fell(sys_rst) |-> word_image == 32'hDB6DB4A2 && !dividers_reset)
      else $error("reset value wrong");
endmodule

bind psc_word_two psc_word_two_sva psc_word_two_sva_inst (
   .ref_clk(ref_clk), .sys_rst(sys_rst), .shared_ctl_n(shared_ctl_n),
   .cfg(cfg), .word_image(word_image), .dividers_reset(dividers_reset),
   .pump_tristate(pump_tristate), .load_done(load_done),
   .frame_reject(frame_reject));

`default_nettype wire

// ===== psc_word_two_test.sv
// Self-checking bench for the serially loaded control word
`timescale 1ns/1ps
`default_nettype none

`define CHK(what, exp, got) begin \
   checked++; \
   if ((got) !== (exp)) begin \
      n_errors++; \
      $display("CHECK FAILED %s exp %0h got %0h", what, exp, got); \
   end \
end

module psc_word_two_test
   import psc_pkg::*;
;
   localparam logic [31:0] DEF = 32'hDB6DB4A2;
   logic ref_clk, sys_rst, ser_clk, ser_data, ser_latch, shared_ctl_n;
   psc_fields_type cfg;
   logic [31:0] word_image;
   logic dividers_reset, pump_tristate, load_done, frame_reject;
   int n_errors = 0;
   int checked = 0;

   psc_word_two psc_word_two_inst (.ref_clk(ref_clk), .sys_rst(sys_rst),
      .ser_clk(ser_clk), .ser_data(ser_data), .ser_latch(ser_latch),
      .shared_ctl_n(shared_ctl_n), .cfg(cfg), .word_image(word_image),
      .dividers_reset(dividers_reset), .pump_tristate(pump_tristate),
      .load_done(load_done), .frame_reject(frame_reject));
   psc_host_model psc_host_model_inst (.ref_clk(ref_clk),
      .ser_clk(ser_clk), .ser_data(ser_data), .ser_latch(ser_latch));

   initial begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end

   task automatic wrap_up();
      if (n_errors == 0 && checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task automatic frame(input logic [31:0] w, input int n, input logic ok);
      psc_host_model_inst.send(w, n);
      for (int k = 0; k < 40 && !(load_done | frame_reject); k++) begin
         @(negedge ref_clk);
      end
      `CHK("outcome", {ok, !ok}, {load_done, frame_reject})
      repeat (2) @(negedge ref_clk);
   endtask

   // Expects the shared pin high
   task automatic check_word(input logic [31:0] w);
      `CHK("image", w, word_image)
      `CHK("polarity", w[2], cfg.pump_polarity)
      `CHK("preset", w[3], cfg.pump_preset_half_supply)
      `CHK("current", w[7:4], cfg.pump_current)
      `CHK("pulse", w[9:8], cfg.detector_pulse_width)
      `CHK("feedback", w[12:10], cfg.feedback_source)
      `CHK("pairs", w[27:13], cfg.pair_source)
      `CHK("sleep_n", w[28], cfg.outputs_sleep_n)
      `CHK("pin_func", w[29], cfg.shared_pin_function)
      `CHK("div_rst", !w[30], dividers_reset)
      `CHK("tristate", !w[31], pump_tristate)
   endtask

   task automatic t_fields();
      frame(32'hA5C33C5A, 32, 1'b1);
      check_word(32'hA5C33C5A);
      frame(32'h5A3CC3A6, 32, 1'b1);
      check_word(32'h5A3CC3A6);
   endtask

   task automatic t_reject();
      for (int i = 0; i < 4; i++) begin
         if (i != 2) begin
            frame({30'h2AAAAAAA, i[1:0]}, 32, 1'b0);
         end
      end
      frame(DEF, 31, 1'b0);
      frame(DEF, 33, 1'b0);
      psc_host_model_inst.stray(3);
      check_word(32'h5A3CC3A6);
   endtask

   task automatic t_pin();
      for (int f = 0; f < 2; f++) begin
         frame({2'h3, f[0], 29'h1B6DB4A2}, 32, 1'b1);
         shared_ctl_n = 1'b0;
         repeat (8) @(negedge ref_clk);
         `CHK("pin_div", !f[0], dividers_reset)
         `CHK("pin_hold", f[0], pump_tristate)
         shared_ctl_n = 1'b1;
         repeat (8) @(negedge ref_clk);
         check_word({2'h3, f[0], 29'h1B6DB4A2});
      end
   endtask

   task automatic t_reset();
      frame(32'hA5C33C5A, 32, 1'b1);
      sys_rst = 1'b1;
      repeat (2) @(negedge ref_clk);
      sys_rst = 1'b0;
      @(negedge ref_clk);
      check_word(DEF);
   endtask

   initial begin
      sys_rst = 1'b1;
      shared_ctl_n = 1'b1;
      repeat (6) @(negedge ref_clk);
      sys_rst = 1'b0;
      repeat (4) @(negedge ref_clk);
      check_word(DEF);
      t_fields();
      t_reject();
      t_pin();
      t_reset();
      wrap_up();
   end

   // Ten frames of about 400 cycles each are expected
   initial begin
      repeat (20000) @(posedge ref_clk);
      n_errors++;
      wrap_up();
   end
endmodule

`default_nettype wire
